// ==== hw/dsc_drum_ctrl.sv ====
// Drum storage controller: order handling, interlaced transfer, faults, APB registers
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dsc_drum_ctrl import dsc_pkg::*; #(
	parameter int BAND_SWITCH_CYCLES = BAND_SWITCH_CYC,
	parameter int ACCESS_MAX_CYCLES = ACCESS_MAX_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ord_valid,
	input wire logic ord_write,
	input wire logic [ADDR_W-1:0] ord_addr,
	input wire logic [CNT_W-1:0] ord_count,
	input wire logic others_busy,
	output logic ord_accept,
	output logic ord_refuse,
	output logic mem_seize,
	output logic cont_pulse,
	output logic word_strobe,
	output logic [WORD_W-1:0] rd_word,
	input wire logic [WORD_W-1:0] wr_word,
	input wire logic pin_ready,
	input wire logic pin_loc,
	input wire logic pin_index,
	input wire logic pin_sense_ok,
	input wire logic [WORD_W-1:0] pin_sense,
	input wire logic [NBANDS-1:0] pin_protect,
	input wire logic pin_protect_all,
	output logic [BAND_W-1:0] band_sel,
	output logic head_en,
	output logic write_gate,
	output logic [WORD_W-1:0] write_pos,
	output logic [WORD_W-1:0] write_neg
);
	typedef struct packed {
		dsc_state_e st;
		logic [PIN_W-1:0] s1;
		logic [PIN_W-1:0] s2;
		logic [PIN_W-1:0] s3;
		logic [PIN_W-1:0] pin;
		logic [LOC_W-1:0] pos;
		logic [LOC_W-1:0] seq;
		logic synced;
		logic wr;
		logic enable;
		logic pready;
		logic pslverr;
		logic accept;
		logic refuse;
		logic seize;
		logic cont;
		logic strobe;
		logic head;
		logic wgate;
		logic [BAND_W-1:0] band;
		logic [CNT_W-1:0] cnt;
		logic [TMR_W-1:0] tmr;
		logic [1:0] fault;
		logic [31:0] prdata;
		logic [WORD_W-1:0] rd_word;
		logic [WORD_W-1:0] wpos;
		logic [WORD_W-1:0] wneg;
	} dsc_regs_s;

	dsc_regs_s r_q;
	dsc_regs_s r_d;
	logic idx_ev;
	logic loc_ev;
	logic lfault;
	logic apb_acc;

	// Word index w sits at location 2w in the first pass, 2w-4095 in the second
	function automatic logic [LOC_W-1:0] dsc_interlace(input logic [LOC_W-1:0] w);
		return {w[LOC_W-2:0], w[LOC_W-1]};
	endfunction

	function automatic logic dsc_protected(input logic [PIN_W-1:0] p, input logic [BAND_W-1:0] b);
		return p[P_PALL] | p[P_PROT + int'(b)];
	endfunction

	always_comb begin
		r_d = r_q;
		// Three-stage filter: a pin level counts only once stages two and three agree
		r_d.s1 = {pin_sense_ok, pin_index, pin_loc, pin_ready, pin_protect_all, pin_protect, pin_sense};
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		r_d.pin = (r_q.s2 & r_q.s3) | (r_q.pin & (r_q.s2 | r_q.s3));
		idx_ev = r_d.pin[P_INDEX] & ~r_q.pin[P_INDEX];
		loc_ev = r_d.pin[P_LOC] & ~r_q.pin[P_LOC];
		lfault = 1'b0;
		apb_acc = psel & penable & ~r_q.pready;
		r_d.accept = 1'b0;
		r_d.refuse = 1'b0;
		r_d.cont = 1'b0;
		r_d.strobe = 1'b0;
		r_d.wgate = 1'b0;
		r_d.wpos = '0;
		r_d.wneg = '0;

		// Index marks location zero arriving; a plain mark is the next location
		if (idx_ev) begin
			if (r_q.synced && r_q.pos != LOC_LAST && r_q.st != DSC_IDLE) begin
				lfault = 1'b1;
			end
			r_d.pos = '0;
			r_d.synced = 1'b1;
		end else if (loc_ev) begin
			if (r_q.synced && r_q.pos == LOC_LAST && r_q.st != DSC_IDLE) begin
				lfault = 1'b1;
			end
			r_d.pos = r_q.pos + 1'b1;
		end

		unique case (r_q.st)
			DSC_IDLE: begin
				if (ord_valid) begin
					if (others_busy || !r_q.pin[P_READY] || !r_q.enable || ord_count == '0) begin
						r_d.refuse = 1'b1;
					end else begin
						r_d.accept = 1'b1;
						r_d.seize = 1'b1;
						r_d.wr = ord_write;
						r_d.band = ord_addr[ADDR_W-1:LOC_W];
						r_d.seq = ord_addr[LOC_W-1:0];
						r_d.cnt = ord_count;
						r_d.fault = '0;
						r_d.tmr = '0;
						r_d.head = 1'b1;
						r_d.st = DSC_SETTLE;
					end
				end
			end
			DSC_SETTLE: begin
				// Same wait for first head setup and for a relay switch; no data moves
				r_d.tmr = r_q.tmr + 1'b1;
				if (r_q.tmr == TMR_W'(BAND_SWITCH_CYCLES - 1)) begin
					r_d.tmr = '0;
					if (r_q.wr && dsc_protected(r_q.pin, r_q.band)) begin
						lfault = 1'b1;
						r_d.st = DSC_FINISH;
					end else begin
						r_d.st = DSC_SEEK;
					end
				end
			end
			DSC_SEEK: begin
				r_d.tmr = r_q.tmr + 1'b1;
				if ((idx_ev || loc_ev) && r_d.pos == dsc_interlace(r_q.seq)) begin
					r_d.tmr = '0;
					r_d.strobe = 1'b1;
					r_d.cnt = r_q.cnt - 1'b1;
					r_d.seq = r_q.seq + 1'b1;
					if (r_q.wr) begin
						r_d.wgate = 1'b1;
						r_d.wpos = wr_word;
						r_d.wneg = ~wr_word;
					end else begin
						r_d.rd_word = r_d.pin[P_WORD +: WORD_W];
						if (!r_d.pin[P_SOK]) begin
							r_d.fault[FLT_READ] = 1'b1;
						end
					end
					if (r_q.cnt == CNT_ONE) begin
						r_d.st = DSC_FINISH;
					end else if (r_q.seq == LOC_LAST) begin
						// Running off band seven has nowhere to go: flagged and ended
						if (r_q.band == BAND_LAST) begin
							lfault = 1'b1;
							r_d.st = DSC_FINISH;
						end else begin
							r_d.band = r_q.band + 1'b1;
							r_d.st = DSC_SETTLE;
						end
					end
				end else if (r_q.tmr == TMR_W'(ACCESS_MAX_CYCLES - 1)) begin
					// No rotation marks at all would otherwise hold memory forever
					lfault = 1'b1;
					r_d.st = DSC_FINISH;
				end
			end
			DSC_FINISH: begin
				r_d.cont = 1'b1;
				r_d.seize = 1'b0;
				r_d.head = 1'b0;
				r_d.tmr = '0;
				r_d.st = DSC_IDLE;
			end
		endcase

		if (lfault) begin
			r_d.fault[FLT_LOC] = 1'b1;
			if (r_q.wr && r_q.st != DSC_FINISH) begin
				r_d.st = DSC_FINISH;
			end
		end

		// APB slave: one wait state, answer on the second access cycle
		r_d.pready = apb_acc;
		r_d.pslverr = 1'b0;
		r_d.prdata = '0;
		if (apb_acc) begin
			case (paddr)
				REG_FAULT: r_d.prdata = {30'h0, r_q.fault};
				REG_STATUS: r_d.prdata = {24'h0, r_q.band, r_q.synced, r_q.st, r_q.head, r_q.seize};
				REG_CTRL: begin
					r_d.prdata = {31'h0, r_q.enable};
					if (pwrite) begin
						r_d.enable = pwdata[CTRL_EN];
					end
				end
				REG_PROGRESS: r_d.prdata = {7'h0, r_q.seq, r_q.cnt};
				default: r_d.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_q <= '0;
			r_q.enable <= CTRL_RST;
		end else begin
			r_q <= r_d;
		end
	end

	assign prdata = r_q.prdata;
	assign pready = r_q.pready;
	assign pslverr = r_q.pslverr;
	assign ord_accept = r_q.accept;
	assign ord_refuse = r_q.refuse;
	assign mem_seize = r_q.seize;
	assign cont_pulse = r_q.cont;
	assign word_strobe = r_q.strobe;
	assign rd_word = r_q.rd_word;
	assign band_sel = r_q.band;
	assign head_en = r_q.head;
	assign write_gate = r_q.wgate;
	assign write_pos = r_q.wpos;
	assign write_neg = r_q.wneg;

	default clocking dsc_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_order_ok;
		r_q.st == DSC_IDLE && ord_valid && !others_busy && r_q.pin[P_READY] && r_q.enable && ord_count != '0;
	endsequence
	sequence s_protect_hit;
		r_q.st == DSC_SETTLE && r_q.wr && dsc_protected(r_q.pin, r_q.band)
			&& r_q.tmr == TMR_W'(BAND_SWITCH_CYCLES - 1);
	endsequence
	sequence s_fault_then_cont;
		r_q.fault[FLT_LOC] ##1 cont_pulse && !mem_seize;
	endsequence

	a_accept_seize: assert property (s_order_ok |=> ord_accept && mem_seize && head_en)
		else $error("Accepted order did not seize memory");
	a_busy_refuse: assert property (r_q.st == DSC_IDLE && ord_valid && others_busy |=> ord_refuse && !mem_seize)
		else $error("Order taken while other input-output busy");
	a_end_continue: assert property ($fell(mem_seize) |-> cont_pulse)
		else $error("Seizure ended without continue");
	a_cont_single: assert property (cont_pulse |=> !cont_pulse && !mem_seize)
		else $error("Continue not a single pulse");
	a_strobe_seized: assert property (word_strobe |-> mem_seize)
		else $error("Word moved outside seizure");
	a_write_polarity: assert property (write_gate |-> write_pos == ~write_neg && !ord_accept)
		else $error("Write currents not opposite");
	a_channel_quiet: assert property (!write_gate |-> write_pos == '0 && write_neg == '0)
		else $error("Write channel driven outside a write");
	a_protect_fault: assert property (s_protect_hit |=> s_fault_then_cont)
		else $error("Protected write not faulted and ended");
	a_interlace_loc: assert property (word_strobe |-> r_q.pos == dsc_interlace($past(r_q.seq)))
		else $error("Word moved at wrong location");
	a_switch_quiet: assert property (r_q.st == DSC_SETTLE && $past(r_q.st) == DSC_SETTLE |-> !word_strobe)
		else $error("Data moved during band switch");
endmodule
`default_nettype wire

// ==== hw/dsc_pkg.sv ====
// Drum storage controller constants, register map and types
// How it works
// - Up to eight bands of 4096 locations, each holding one 48-bit word
// - Consecutive words go to every second location; a band takes two revolutions
// - Controller turns the sequential word address into the physical location
// - Order refused unless all other input-output is idle and drum available
// - Accepted order seizes main memory until the order ends
// - Any count from one to 4096 words, starting at any location
// - On acceptance the order parameters load into controller registers
// - Select band, settle heads, start when first word's location arrives
// - Read delivers one whole 48-bit word at a time to the buffer
// - Write takes one whole 48-bit word at a time onto the band
// - One set of read and write channels, joined only to the active band
// - Past location 4095 continue at location zero of the next band
// - Bands zero to seven; no data moves while a band switch settles
// - Location fault on misplaced location zero; reading fault on missing bits
// - Location fault ends a write order; reading fault never ends an order
// - Continue signal after every ended order, completed or terminated
// - Protected band still reads; a write is accepted but raises location fault
// - Protection for all bands together or any chosen subset of bands
// - Ones and zeros are written with opposite current polarity
package dsc_pkg;
	localparam int WORD_W = 48;
	localparam int LOC_W = 12;
	localparam int BAND_W = 3;
	localparam int CNT_W = 13;
	localparam int ADDR_W = 15;
	localparam int NBANDS = 8;
	localparam logic [LOC_W-1:0] LOC_LAST = 12'hfff;
	localparam logic [BAND_W-1:0] BAND_LAST = 3'h7;
	localparam logic [CNT_W-1:0] CNT_ONE = 13'h0001;
	localparam int CLK_HZ = 50_000_000;
	localparam int BAND_SWITCH_US = 8000;
	localparam int ACCESS_MAX_US = 34000;
	localparam int BAND_SWITCH_CYC = BAND_SWITCH_US * (CLK_HZ / 1_000_000);
	localparam int ACCESS_MAX_CYC = ACCESS_MAX_US * (CLK_HZ / 1_000_000);
	localparam int TMR_W = 21;
	localparam logic [7:0] REG_FAULT = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_PROGRESS = 8'h0c;
	localparam int FLT_LOC = 0;
	localparam int FLT_READ = 1;
	localparam int CTRL_EN = 0;
	localparam logic CTRL_RST = 1'b1;
	localparam int P_WORD = 0;
	localparam int P_PROT = 48;
	localparam int P_PALL = 56;
	localparam int P_READY = 57;
	localparam int P_LOC = 58;
	localparam int P_INDEX = 59;
	localparam int P_SOK = 60;
	localparam int PIN_W = 61;
	typedef enum logic [1:0] {
		DSC_IDLE = 2'b00,
		DSC_SETTLE = 2'b01,
		DSC_SEEK = 2'b10,
		DSC_FINISH = 2'b11
	} dsc_state_e;
endpackage

// ==== tb/dsc_drum_model.sv ====
// Behavioural drum: rotating locations, index mark and sensed words
`timescale 1ns/1ps
`default_nettype none
module dsc_drum_model import dsc_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [BAND_W-1:0] band,
	input wire logic heads,
	input wire logic ok_in,
	output logic pin_loc,
	output logic pin_index,
	output logic [WORD_W-1:0] pin_sense,
	output logic pin_sense_ok,
	output logic [LOC_W-1:0] loc
);
	logic [2:0] ph;
	logic [WORD_W-1:0] w;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph <= 3'h0;
			loc <= 12'hff0;
		end else begin
			ph <= ph + 3'h1;
			if (ph == 3'h7) loc <= loc + 12'h001;
		end
	end
	// Each mark level lasts four cycles, what the pin filter needs
	assign pin_loc = ph < 3'h4 && loc != 12'h000;
	assign pin_index = ph < 3'h4 && loc == 12'h000;
	assign w = {band, loc, ~loc, loc, 9'h000};
	// Unselected heads give the inverse, so a stale word cannot match
	assign pin_sense = heads ? w : ~w;
	assign pin_sense_ok = ok_in;
endmodule
`default_nettype wire

// ==== tb/test_drum_storage_controller.sv ====
// Self-checking bench for the drum storage controller
`timescale 1ns/1ps
`default_nettype none
module test_drum_storage_controller import dsc_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic ord_valid, ord_write, others_busy, ord_accept, ord_refuse, mem_seize, cont_pulse, word_strobe;
	logic [ADDR_W-1:0] ord_addr, a;
	logic [CNT_W-1:0] ord_count;
	logic [WORD_W-1:0] rd_word, wr_word, pin_sense, write_pos, write_neg;
	logic pin_loc, pin_index, pin_sense_ok, pin_protect_all, head_en, write_gate, ok_in;
	logic [NBANDS-1:0] pin_protect;
	logic [BAND_W-1:0] band_sel;
	logic [LOC_W-1:0] loc;
	logic [WORD_W-1:0] got[$];
	logic [32:0] r;
	logic [1:0] res;
	logic acc, refd, fin, on, pin_ready;
	int n_fail, checked, bad;
	dsc_drum_ctrl #(.BAND_SWITCH_CYCLES(8), .ACCESS_MAX_CYCLES(40000)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ord_valid, .ord_write, .ord_addr, .ord_count,
		.others_busy, .ord_accept, .ord_refuse, .mem_seize, .cont_pulse, .word_strobe, .rd_word, .wr_word,
		.pin_ready, .pin_loc, .pin_index, .pin_sense_ok, .pin_sense, .pin_protect, .pin_protect_all,
		.band_sel, .head_en, .write_gate, .write_pos, .write_neg);
	dsc_drum_model i_drum (.clk(pclk), .rst_n(presetn), .band(band_sel), .heads(head_en), .ok_in, .pin_loc,
		.pin_index, .pin_sense, .pin_sense_ok, .loc);
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (word_strobe) got.push_back(write_gate ? write_pos : rd_word);
		if (write_gate && (write_neg !== ~write_pos || !word_strobe)) bad++;
		acc |= ord_accept;
		refd |= ord_refuse;
		fin |= cont_pulse | ord_refuse;
		if (ord_accept) on = 1;
		if (cont_pulse) on = 0;
		if (presetn && mem_seize !== on) bad++;
	end
	function automatic logic [WORD_W-1:0] pat(input logic [2:0] b, input logic [11:0] l);
		return {b, l, ~l, l, 9'h000};
	endfunction
	// Even location a little ahead of the heads keeps every seek short
	function automatic logic [ADDR_W-1:0] near(input logic [2:0] b);
		logic [11:0] l;
		l = loc + 12'h028;
		return {b, 1'b0, l[11:1]};
	endfunction
	task chk(input logic [WORD_W-1:0] e, input logic [WORD_W-1:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		r = {pslverr, prdata};
		psel <= 0;
		penable <= 0;
		if (i == 20) begin
			n_fail++;
			test_done();
		end
		// One idle cycle so the next call never sets psel in the step that cleared it
		@(posedge pclk);
	endtask
	task run(input logic w, input logic [ADDR_W-1:0] ad, input logic [CNT_W-1:0] c);
		int i;
		got.delete();
		{acc, refd, fin} = 0;
		ord_valid <= 1;
		ord_write <= w;
		ord_addr <= ad;
		ord_count <= c;
		@(posedge pclk) ord_valid <= 0;
		for (i = 0; i < 50000 && !fin; i++) @(posedge pclk);
		@(posedge pclk) res = {acc, refd};
		if (i == 50000) begin
			n_fail++;
			test_done();
		end
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ord_valid, ord_write, ord_addr, ord_count} = 0;
		{others_busy, wr_word, pin_protect, pin_protect_all, bad, n_fail, checked, on} = 0;
		ok_in = 1;
		pin_ready = 1;
		presetn = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		repeat (200) @(posedge pclk);
		apb(0, REG_CTRL, 0); chk(1, r);
		apb(1, REG_FAULT, 32'h3); apb(0, REG_FAULT, 0); chk(0, r);
		apb(0, 8'h10, 0); chk(33'h100000000, r);
		$display("test registers done");
		others_busy <= 1; run(0, 0, 1); chk(1, res);
		others_busy <= 0; run(0, 0, 0); chk(1, res);
		apb(1, REG_CTRL, 0); run(0, 0, 1); chk(1, res); apb(1, REG_CTRL, 1);
		pin_ready <= 0;
		repeat (6) @(posedge pclk);
		run(0, 0, 1); chk(1, res);
		pin_ready <= 1;
		repeat (6) @(posedge pclk);
		a = near(2); run(0, a, 2); chk(2, res);
		chk(pat(2, {a[10:0], a[11]}), got[0]);
		chk(pat(2, {a[10:0], a[11]} + 12'h002), got[1]);
		$display("test read done");
		for (int i = 0; i < 40000 && loc != 12'hfe0; i++) @(posedge pclk);
		run(0, 15'h0fff, 2); chk(2, got.size());
		chk(pat(0, 12'hfff), got[0]); chk(pat(1, 0), got[1]);
		$display("test band switch done");
		for (int k = 0; k < 2; k++) begin
			pin_protect <= k ? 8'h00 : 8'h08;
			pin_protect_all <= k[0];
			run(1, near(3), 1); chk(2, res); chk(0, got.size());
			apb(0, REG_FAULT, 0); chk(1, r);
		end
		{pin_protect, pin_protect_all} <= 0;
		wr_word <= 48'h5a5a0f0fc3c3;
		run(1, near(5), 1); chk(wr_word, got[0]);
		apb(0, REG_FAULT, 0); chk(0, r);
		ok_in <= 0;
		run(0, near(6), 1); chk(1, got.size());
		apb(0, REG_FAULT, 0); chk(2, r);
		$display("test faults done");
		chk(0, bad);
		test_done();
	end
endmodule
`default_nettype wire
